/* File: diag_cfg_pkg.sv */
package diag_cfg_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_GLOBAL_CONFIGURATION = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_PIN_STATE = 8'h0C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // step input filter defaults to on, everything else off
    localparam logic [31:0] GLOBAL_CONFIGURATION_RESET = 32'h0000_0002;
    localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ------------------------------------------------------------
    // global configuration field positions
    // ------------------------------------------------------------
    localparam int BIT_AXIS0_STEP_INPUT_FILTER = 1;
    localparam int BIT_AXIS0_DIRECTION_INVERT = 2;
    localparam int BIT_PIN_A_DRIVER_FAULT = 3;
    localparam int BIT_PIN_A_THERMAL_PREWARN = 4;
    localparam int BIT_PIN_A_STALL_OR_STEP = 5;
    localparam int BIT_PIN_B_STALL_OR_DIRECTION = 6;
    localparam int BIT_AXIS0_INDEX_ON_PIN_B = 7;
    localparam int BIT_PIN_A_DRIVE_TYPE = 8;
    localparam int BIT_PIN_B_DRIVE_TYPE = 9;
    localparam int BIT_PIN_A_IRQ_SOURCE_LO = 19;
    localparam int BIT_PIN_A_IRQ_SOURCE_HI = 20;
    localparam int BIT_PIN_A_FUNCTION_SELECT = 29;
    localparam int BIT_PIN_B_FUNCTION_SELECT = 30;

    // ------------------------------------------------------------
    // interrupt status layout and irq source encodings
    // ------------------------------------------------------------
    localparam int EVT_PIN_A_ASSERT = 0;
    localparam int EVT_PIN_B_ASSERT = 1;
    localparam int EVT_DRIVER_FAULT = 2;
    localparam int EVT_THERMAL_PREWARN = 3;
    localparam int EVT_COUNT = 4;
    localparam logic [1:0] IRQ_SRC_EITHER = 2'h0;
    localparam logic [1:0] IRQ_SRC_CTRL0 = 2'h1;
    localparam logic [1:0] IRQ_SRC_CTRL1 = 2'h2;
    localparam logic [1:0] IRQ_SRC_BOTH = 2'h3;
endpackage : diag_cfg_pkg

/* File: diag_route_if.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// configuration and source levels passed to the pin router
// ------------------------------------------------------------
interface diag_route_if #(parameter int MSTEP_W = 10);
    logic [31:0] cfg;
    logic [MSTEP_W-1:0] mstep_pos;
    logic stall;
    logic pos_compare;
    logic ramp_dir;
    logic ramp_step;
    logic ctrl0_irq;
    logic ctrl1_irq;
    logic overheat_fault;
    logic short_to_ground;
    logic thermal_prewarn;
    logic reset_hold;
    logic act_a;
    logic act_b;
    modport ctrl (output cfg, mstep_pos, stall, pos_compare, ramp_dir, ramp_step,
        ctrl0_irq, ctrl1_irq, overheat_fault, short_to_ground, thermal_prewarn,
        reset_hold, input act_a, act_b);
    modport route (input cfg, mstep_pos, stall, pos_compare, ramp_dir, ramp_step,
        ctrl0_irq, ctrl1_irq, overheat_fault, short_to_ground, thermal_prewarn,
        reset_hold, output act_a, act_b);
endinterface : diag_route_if

/* File: diag_route.sv */
`timescale 1ns/1ns
module diag_route (
    // configuration and sources in, active levels out
    diag_route_if.route rif
);
    // ------------------------------------------------------------
    // motion controller interrupt merge
    // ------------------------------------------------------------
    function automatic logic irq_merge(input logic [1:0] sel, input logic i0, input logic i1);
        case (sel)
            diag_cfg_pkg::IRQ_SRC_EITHER: irq_merge = i0 | i1;
            diag_cfg_pkg::IRQ_SRC_CTRL0: irq_merge = i0;
            diag_cfg_pkg::IRQ_SRC_CTRL1: irq_merge = i1;
            default: irq_merge = i0 & i1;
        endcase
    endfunction : irq_merge

    logic [1:0] irq_sel;
    logic ramp_a;
    logic ramp_b;

    // pin a: ramp branch picks step or interrupts, otherwise stall
    assign irq_sel = rif.cfg[diag_cfg_pkg::BIT_PIN_A_IRQ_SOURCE_HI:diag_cfg_pkg::BIT_PIN_A_IRQ_SOURCE_LO];
    assign ramp_a = rif.cfg[diag_cfg_pkg::BIT_PIN_A_STALL_OR_STEP] ? rif.ramp_step
        : irq_merge(irq_sel, rif.ctrl0_irq, rif.ctrl1_irq);
    // all enabled sources are or-ed; reset hold wins regardless of setup
    assign rif.act_a = rif.reset_hold
        | (rif.cfg[diag_cfg_pkg::BIT_PIN_A_DRIVER_FAULT]
           & (rif.overheat_fault | rif.short_to_ground))
        | (rif.cfg[diag_cfg_pkg::BIT_PIN_A_THERMAL_PREWARN] & rif.thermal_prewarn)
        | (rif.cfg[diag_cfg_pkg::BIT_PIN_A_FUNCTION_SELECT] ? ramp_a
           : (rif.cfg[diag_cfg_pkg::BIT_PIN_A_STALL_OR_STEP] & rif.stall));

    // pin b: ramp branch picks direction or position compare
    assign ramp_b = rif.cfg[diag_cfg_pkg::BIT_PIN_B_STALL_OR_DIRECTION] ? rif.ramp_dir
        : rif.pos_compare;
    assign rif.act_b = (rif.cfg[diag_cfg_pkg::BIT_AXIS0_INDEX_ON_PIN_B]
           & (rif.mstep_pos == '0))
        | (rif.cfg[diag_cfg_pkg::BIT_PIN_B_FUNCTION_SELECT] ? ramp_b
           : (rif.cfg[diag_cfg_pkg::BIT_PIN_B_STALL_OR_DIRECTION] & rif.stall));
endmodule : diag_route

/* File: diag_pin_drive.sv */
`timescale 1ns/1ns
module diag_pin_drive #(
    parameter bit RESET_ACTIVE = 1'b0
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    // requested level and drive type
    input wire logic active,
    input wire logic push_pull,
    // pin as output level and enable
    output logic pin_out,
    output logic pin_oe
);
    // ------------------------------------------------------------
    // active-low pin: open collector releases, push-pull drives high
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 1'b0;
            pin_oe <= RESET_ACTIVE;
        end else if (ce) begin
            pin_oe <= active | push_pull;
            // open collector never drives high, so out stays low when released
            pin_out <= push_pull & ~active;
        end
    end
endmodule : diag_pin_drive

/* File: diag_pin_config_axis0.sv */
`timescale 1ns/1ns
module diag_pin_config_axis0 #(
    parameter int MSTEP_W = 10
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // diagnostic sources from the core
    input wire logic axis0_stall,
    input wire logic [MSTEP_W-1:0] axis0_mstep_pos,
    input wire logic pos_compare,
    input wire logic ramp0_dir,
    input wire logic ramp0_step,
    input wire logic ctrl0_irq,
    input wire logic ctrl1_irq,
    input wire logic overheat_fault,
    input wire logic short_to_ground,
    input wire logic thermal_prewarn,
    input wire logic device_reset_hold,
    // diagnostic pins, active low
    output logic diag_pin_a_out,
    output logic diag_pin_a_oe,
    output logic diag_pin_b_out,
    output logic diag_pin_b_oe,
    // axis 0 controls
    output logic axis0_direction_invert,
    output logic axis0_step_input_filter,
    // interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    generate
        if (MSTEP_W < 1 || MSTEP_W > 16) begin : g_bad_width
            $error("MSTEP_W must lie between 1 and 16");
        end
    endgenerate

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    diag_route_if #(.MSTEP_W(MSTEP_W)) rif ();

    logic [31:0] global_configuration_reg;
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] mask_reg;
    logic [3:0] events;
    logic [3:0] wr_clear;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic act_a_prev_reg;
    logic act_b_prev_reg;
    logic fault_prev_reg;
    logic prewarn_prev_reg;
    logic fault_now;
    logic setup_phase;
    logic wr_fire;
    logic [31:0] rd_word;
    logic rd_hit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a level that just rose
    function automatic logic rose(input logic now, input logic prev);
        rose = now & ~prev;
    endfunction : rose

    // word address decode, shared by read mux and write strobes
    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
        is_reg = (addr == ofs);
    endfunction : is_reg

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    assign setup_phase = psel & ~penable;
    assign wr_fire = ce & psel & penable & pready_reg & pwrite;

    // one wait-free access cycle after every setup cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= setup_phase;
        end
    end

    // read mux; reserved status bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (is_reg(paddr, diag_cfg_pkg::OFS_GLOBAL_CONFIGURATION)) begin
            rd_word = global_configuration_reg;
        end else if (is_reg(paddr, diag_cfg_pkg::OFS_IRQ_STATUS)) begin
            rd_word = {28'h0000000, status_reg};
        end else if (is_reg(paddr, diag_cfg_pkg::OFS_IRQ_MASK)) begin
            rd_word = {28'h0000000, mask_reg};
        end else if (is_reg(paddr, diag_cfg_pkg::OFS_PIN_STATE)) begin
            rd_word = {28'h0000000, diag_pin_b_oe, diag_pin_b_out, diag_pin_a_oe, diag_pin_a_out};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // answer is captured in setup so it comes straight from a flop
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            if (setup_phase) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr_reg <= ~rd_hit;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    // all 32 bits are stored so software reads back what it wrote
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_configuration_reg <= diag_cfg_pkg::GLOBAL_CONFIGURATION_RESET;
        end else if (wr_fire && is_reg(paddr, diag_cfg_pkg::OFS_GLOBAL_CONFIGURATION)) begin
            global_configuration_reg <= pwdata;
        end
    end

    // mask register, same layout as status
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= diag_cfg_pkg::IRQ_MASK_RESET;
        end else if (wr_fire && is_reg(paddr, diag_cfg_pkg::OFS_IRQ_MASK)) begin
            mask_reg <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // routing and pin drivers
    // ------------------------------------------------------------
    assign rif.cfg = global_configuration_reg;
    assign rif.mstep_pos = axis0_mstep_pos;
    assign rif.stall = axis0_stall;
    assign rif.pos_compare = pos_compare;
    assign rif.ramp_dir = ramp0_dir;
    assign rif.ramp_step = ramp0_step;
    assign rif.ctrl0_irq = ctrl0_irq;
    assign rif.ctrl1_irq = ctrl1_irq;
    assign rif.overheat_fault = overheat_fault;
    assign rif.short_to_ground = short_to_ground;
    assign rif.thermal_prewarn = thermal_prewarn;
    assign rif.reset_hold = device_reset_hold;

    diag_route u_route (
        .rif(rif.route)
    );

    // pin a resets active so a held reset shows on it at once
    diag_pin_drive #(.RESET_ACTIVE(1'b1)) u_pin_a (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .active(rif.act_a),
        .push_pull(global_configuration_reg[diag_cfg_pkg::BIT_PIN_A_DRIVE_TYPE]),
        .pin_out(diag_pin_a_out),
        .pin_oe(diag_pin_a_oe)
    );

    diag_pin_drive #(.RESET_ACTIVE(1'b0)) u_pin_b (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .active(rif.act_b),
        .push_pull(global_configuration_reg[diag_cfg_pkg::BIT_PIN_B_DRIVE_TYPE]),
        .pin_out(diag_pin_b_out),
        .pin_oe(diag_pin_b_oe)
    );

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    assign fault_now = overheat_fault | short_to_ground;

    // previous levels for edge detection
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            act_a_prev_reg <= 1'b0;
            act_b_prev_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
            prewarn_prev_reg <= 1'b0;
        end else if (ce) begin
            act_a_prev_reg <= rif.act_a;
            act_b_prev_reg <= rif.act_b;
            fault_prev_reg <= fault_now;
            prewarn_prev_reg <= thermal_prewarn;
        end
    end

    always_comb begin
        events = 4'h0;
        events[diag_cfg_pkg::EVT_PIN_A_ASSERT] = rose(rif.act_a, act_a_prev_reg);
        events[diag_cfg_pkg::EVT_PIN_B_ASSERT] = rose(rif.act_b, act_b_prev_reg);
        events[diag_cfg_pkg::EVT_DRIVER_FAULT] = rose(fault_now, fault_prev_reg);
        events[diag_cfg_pkg::EVT_THERMAL_PREWARN] = rose(thermal_prewarn, prewarn_prev_reg);
    end

    // write one to clear; a new event in the same cycle wins over the clear
    assign wr_clear = (wr_fire && is_reg(paddr, diag_cfg_pkg::OFS_IRQ_STATUS)) ? pwdata[3:0] : 4'h0;
    assign status_next = (status_reg & ~wr_clear) | events;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= diag_cfg_pkg::IRQ_STATUS_RESET;
        end else if (ce) begin
            status_reg <= status_next;
        end
    end

    // level output, one cycle behind the status so it comes from a flop
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign axis0_direction_invert = global_configuration_reg[diag_cfg_pkg::BIT_AXIS0_DIRECTION_INVERT];
    assign axis0_step_input_filter = global_configuration_reg[diag_cfg_pkg::BIT_AXIS0_STEP_INPUT_FILTER];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_global_configuration_write;
        wr_fire && paddr == diag_cfg_pkg::OFS_GLOBAL_CONFIGURATION;
    endsequence

    sequence s_b_index_open_drain;
        ce && global_configuration_reg[7] && !global_configuration_reg[9] && axis0_mstep_pos == '0;
    endsequence

    AST_PIN_B_OPEN_DRAIN: assert property (s_b_index_open_drain |=> diag_pin_b_oe && !diag_pin_b_out)
        else $error("pin b not pulled low in open collector mode");

    AST_PIN_A_PUSH_PULL_IDLE: assert property (ce && global_configuration_reg[8] && !rif.act_a
        |=> diag_pin_a_oe && diag_pin_a_out)
        else $error("pin a push-pull idle not driven high");

    AST_INDEX_OFF: assert property (ce && !global_configuration_reg[7] && !global_configuration_reg[6] && !global_configuration_reg[30]
        && !global_configuration_reg[9] |=> !diag_pin_b_oe)
        else $error("pin b driven with index and stall disabled");

    AST_STALL_B: assert property (ce && !global_configuration_reg[30] && global_configuration_reg[6] && axis0_stall
        |=> diag_pin_b_oe && !diag_pin_b_out)
        else $error("stall not shown on pin b");

    AST_POS_COMPARE_B: assert property (ce && global_configuration_reg[30] && !global_configuration_reg[6] && !global_configuration_reg[7]
        |=> diag_pin_b_out == ($past(global_configuration_reg[9]) & ~$past(pos_compare)))
        else $error("pin b does not follow position compare");

    AST_DIR_B: assert property (ce && global_configuration_reg[30] && global_configuration_reg[6] && ramp0_dir
        |=> !diag_pin_b_out && diag_pin_b_oe)
        else $error("pin b does not follow ramp direction");

    // reset is still sampled low at the release edge, when pin a shows its reset value
    AST_STALL_A_OFF: assert property (rst_b && ce && !global_configuration_reg[29] && !global_configuration_reg[3]
        && !global_configuration_reg[4] && !device_reset_hold && !global_configuration_reg[8]
        |=> !diag_pin_a_oe || $past(global_configuration_reg[5] & axis0_stall))
        else $error("pin a driven with no enabled source");

    AST_IRQ_BOTH_A: assert property (ce && global_configuration_reg[29] && !global_configuration_reg[5]
        && global_configuration_reg[20:19] == 2'h3 && ctrl0_irq && ctrl1_irq |=> diag_pin_a_oe && !diag_pin_a_out)
        else $error("merged controller interrupts not on pin a");

    AST_STEP_A: assert property (ce && global_configuration_reg[29] && global_configuration_reg[5] && ramp0_step
        |=> diag_pin_a_oe && !diag_pin_a_out)
        else $error("ramp step not on pin a");

    AST_PREWARN_A: assert property (ce && global_configuration_reg[4] && thermal_prewarn
        |=> !diag_pin_a_out && diag_pin_a_oe)
        else $error("prewarning not on pin a");

    AST_FAULT_A: assert property (ce && global_configuration_reg[3] && short_to_ground
        |=> !diag_pin_a_out && diag_pin_a_oe)
        else $error("driver fault not on pin a");

    AST_RESET_HOLD_A: assert property (ce && device_reset_hold [*2]
        |=> diag_pin_a_oe && !diag_pin_a_out)
        else $error("pin a released during reset hold");

    AST_SHAFT_WRITE: assert property (s_global_configuration_write
        |=> axis0_direction_invert == $past(pwdata[2]))
        else $error("direction invert did not take written value");

    // set wins over a clear in the same cycle, so an event is never lost
    AST_STATUS_SET_WINS: assert property (ce && events[0] |=> status_reg[0])
        else $error("pin a event lost from status");

    // interrupt level trails the masked status by one cycle
    AST_IRQ_LEVEL: assert property (ce |=> irq == $past(|(status_reg & mask_reg)))
        else $error("interrupt level does not follow masked status");
endmodule : diag_pin_config_axis0

/* File: diag_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// host side: resolves both diagnostic pins as wires
// ------------------------------------------------------------
module diag_host_model (
    // pin drive from the block
    input wire logic a_out,
    input wire logic a_oe,
    input wire logic b_out,
    input wire logic b_oe,
    // levels the host sees
    output logic lvl_a,
    output logic lvl_b
);
    // released pins float up to the external pull-up, so idle reads high
    assign lvl_a = a_oe ? a_out : 1'b1;
    assign lvl_b = b_oe ? b_out : 1'b1;
endmodule : diag_host_model

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
    // ------------------------------------------------------------
    // clock, bus and source signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, ev, irq, dinv, filt;
    logic [9:0] src = 10'h000;
    logic [9:0] mpos = 10'h001;
    logic ao, ae, bo, be, lvl_a, lvl_b;
    int mismatches = 0, checks_done = 0, cyc = 0;

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    diag_pin_config_axis0 #(.MSTEP_W(10)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .axis0_stall(src[0]), .pos_compare(src[1]), .ramp0_dir(src[2]),
        .ramp0_step(src[3]), .ctrl0_irq(src[4]), .ctrl1_irq(src[5]),
        .overheat_fault(src[6]), .short_to_ground(src[7]), .thermal_prewarn(src[8]),
        .device_reset_hold(src[9]), .axis0_mstep_pos(mpos), .diag_pin_a_out(ao),
        .diag_pin_a_oe(ae), .diag_pin_b_out(bo), .diag_pin_b_oe(be),
        .axis0_direction_invert(dinv), .axis0_step_input_filter(filt), .irq(irq));

    diag_host_model host (.a_out(ao), .a_oe(ae), .b_out(bo), .b_oe(be), .lvl_a(lvl_a),
        .lvl_b(lvl_b));

    // ------------------------------------------------------------
    // compare, bus and scenario tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; waits on pready as long as it takes, the hang guard ends a stuck wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask : rd_chk

    // s[10] puts the microstep position on index zero
    task scen(input logic [31:0] g, input logic [10:0] s, input logic ea, input logic eb);
        @(posedge sys_clk);
        src <= s[9:0];
        mpos <= s[10] ? 10'h000 : 10'h001;
        apb(1'b1, 8'h00, g);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({30'h0, lvl_a, lvl_b}, {30'h0, ea, eb});
    endtask : scen

    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        chk({31'h0, lvl_a}, 32'h0);
        chk({31'h0, filt}, 32'h1);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_chk(8'h00, 32'h0000_0002);
        rd_chk(8'h08, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        scen(32'h0000_0002, 11'h001, 1'b1, 1'b1);
        scen(32'h0000_0042, 11'h001, 1'b1, 1'b0);
        scen(32'h0000_0022, 11'h001, 1'b0, 1'b1);
        scen(32'h0000_0082, 11'h400, 1'b1, 1'b0);
        scen(32'h0000_0082, 11'h000, 1'b1, 1'b1);
        scen(32'h4000_0002, 11'h002, 1'b1, 1'b0);
        scen(32'h4000_0002, 11'h001, 1'b1, 1'b1);
        scen(32'h4000_0042, 11'h004, 1'b1, 1'b0);
        scen(32'h4000_0042, 11'h003, 1'b1, 1'b1);
        scen(32'h2000_0022, 11'h008, 1'b0, 1'b1);
        scen(32'h2000_0022, 11'h001, 1'b1, 1'b1);
        scen(32'h2000_0002, 11'h010, 1'b0, 1'b1);
        scen(32'h2000_0002, 11'h020, 1'b0, 1'b1);
        scen(32'h2008_0002, 11'h010, 1'b0, 1'b1);
        scen(32'h2008_0002, 11'h020, 1'b1, 1'b1);
        scen(32'h2010_0002, 11'h020, 1'b0, 1'b1);
        scen(32'h2010_0002, 11'h010, 1'b1, 1'b1);
        scen(32'h2018_0002, 11'h010, 1'b1, 1'b1);
        scen(32'h2018_0002, 11'h030, 1'b0, 1'b1);
        scen(32'h0000_0012, 11'h100, 1'b0, 1'b1);
        scen(32'h0000_0002, 11'h1C0, 1'b1, 1'b1);
        scen(32'h0000_000A, 11'h040, 1'b0, 1'b1);
        scen(32'h0000_000A, 11'h080, 1'b0, 1'b1);
        scen(32'h0000_003A, 11'h100, 1'b0, 1'b1);
        scen(32'h0000_0002, 11'h200, 1'b0, 1'b1);
        scen(32'h0000_0302, 11'h000, 1'b1, 1'b1);
        rd_chk(8'h0C, 32'h0000_000F);
        scen(32'h0000_0342, 11'h001, 1'b1, 1'b0);
        rd_chk(8'h0C, 32'h0000_000B);
        scen(32'h0000_0022, 11'h001, 1'b0, 1'b1);
        rd_chk(8'h0C, 32'h0000_0002);
        // pin state is read only, a write must leave it alone
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rd_chk(8'h0C, 32'h0000_0002);
        scen(32'h0000_0004, 11'h000, 1'b1, 1'b1);
        chk({30'h0, dinv, filt}, 32'h2);
        rd_chk(8'h00, 32'h0000_0004);
        // interrupt: clear, raise, mask in, then clear again
        apb(1'b1, 8'h04, 32'h0000_000F);
        rd_chk(8'h04, 32'h0000_0000);
        scen(32'h0000_0022, 11'h001, 1'b0, 1'b1);
        rd_chk(8'h04, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h08, 32'h0000_0001);
        rd_chk(8'h08, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        scen(32'h0000_0002, 11'h000, 1'b1, 1'b1);
        apb(1'b1, 8'h04, 32'h0000_0001);
        rd_chk(8'h04, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        stop_test();
    end
endmodule : tb
